/* core/cwg_pkg.sv */
package cwg_pkg;

   // ****************************************
   // Register map, byte addresses
   // ****************************************
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] POL_OFS = 8'h04;
   localparam logic [7:0] DBR_OFS = 8'h08;
   localparam logic [7:0] DBF_OFS = 8'h0c;
   localparam logic [7:0] SHDN_OFS = 8'h10;
   localparam logic [7:0] STAT_OFS = 8'h14;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;
   localparam int unsigned CTRL_CS_BIT = 4;
   localparam int unsigned SHDN_STATE_BIT = 0;
   localparam int unsigned SHDN_AUTO_BIT = 1;
   localparam int unsigned SHDN_OVR_LSB = 4;
   localparam int unsigned STAT_OUT_LSB = 0;
   localparam int unsigned STAT_DIR_BIT = 4;
   localparam int unsigned STAT_PHASE_BIT = 5;
   localparam int unsigned STAT_DATA_BIT = 6;
   localparam int unsigned STAT_SHDN_BIT = 7;

   // ****************************************
   // Mode codes and dead-band sizes
   // ****************************************
   localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
   localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
   localparam logic [2:0] MODE_FB_FWD = 3'h2;
   localparam logic [2:0] MODE_FB_REV = 3'h3;
   localparam logic [2:0] MODE_HALF_BRIDGE = 3'h4;
   localparam logic [2:0] MODE_PUSH_PULL = 3'h5;
   localparam int unsigned DB_W = 6;
   localparam logic [DB_W-1:0] DB_MAX = 6'h3f;
   localparam logic [DB_W-1:0] DB_ZERO = 6'h00;

   // ****************************************
   // Carriers and states
   // ****************************************
   typedef struct packed {
      logic en;
      logic [2:0] mode;
      logic cs;
      logic [3:0] pol;
      logic [DB_W-1:0] dbr;
      logic [DB_W-1:0] dbf;
      logic auto_restart;
      logic [3:0] ovr;
   } cfg_t;

   typedef struct packed {
      logic shdn;
      logic data;
      logic phase;
      logic dir;
      logic [3:0] outs;
   } stat_t;

   localparam cfg_t CFG_RESET = '0;
   localparam logic [3:0] OUT_RESET = 4'h0;

   typedef enum logic {DB_IDLE, DB_WAIT} fb_db_state_t;

endpackage

/* core/complementary_waveform_gen.sv */
`timescale 1ns/1ps
// What this block does
// - six modes, one input, four outputs, shutdown
// - two 6-bit dead-band timers, rise and fall
// - half bridge: A true, B inverted, non-overlap
// - half bridge: C, D follow A, B
// - steering ignored outside steering modes
// - push-pull: pulses alternate between A and B
// - push-pull sequencer resets on disable or shutdown
// - first pulse after reset goes to A
// - push-pull: C, D copy A, B
// - forward: A active, B C inactive, D modulated
// - reverse: C active, A D inactive, B modulated
// - direction toggles by mode bit 0 while running
// - direction change waits for next data rise
// - statics swap, modulation resumes after dead band
// - bridge dead band only on new modulated output
// - data rise gives rising modulated output
// - each output has its own polarity
// - dead band counts clock periods up to value
// - half bridge counts set turn-on delays
// - dead-band clock is system or fast oscillator
module complementary_waveform_gen
   import cwg_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic data_in,
   input wire logic fast_internal_oscillator,
   input wire logic shutdown_in,
   output logic bridge_out_a,
   output logic bridge_out_b,
   output logic bridge_out_c,
   output logic bridge_out_d
);

   // Assertion clock and reset for the whole block
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ****************************************
   // Helpers
   // ****************************************

   // Saturating dead-band count step
   function automatic logic [DB_W-1:0] db_step(input logic [DB_W-1:0] cnt, input logic tick);
      logic [DB_W-1:0] nxt;
      nxt = cnt;
      if (tick && cnt != DB_MAX) begin
         nxt = cnt + 6'h01;
      end
      return nxt;
   endfunction

   // ****************************************
   // State
   // ****************************************
   cfg_t cfg_q, cfg_d;
   logic shdn_q, shdn_d;
   logic data_q;
   logic phase_q, phase_d;
   logic dir_q, dir_d;
   fb_db_state_t fbst_q, fbst_d;
   logic [DB_W-1:0] rcnt_q, rcnt_d;
   logic [DB_W-1:0] fcnt_q, fcnt_d;
   logic [DB_W-1:0] dcnt_q, dcnt_d;
   logic [3:0] out_q, out_d;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;

   // ****************************************
   // APB slave decode
   // ****************************************

   // One wait state: ready rises in the second access cycle
   wire access = psel && penable;
   wire done = access && pready_q;
   wire wr_fire = done && pwrite;
   wire hit_ctrl = paddr == CTRL_OFS;
   wire hit_pol = paddr == POL_OFS;
   wire hit_dbr = paddr == DBR_OFS;
   wire hit_dbf = paddr == DBF_OFS;
   wire hit_shdn = paddr == SHDN_OFS;
   wire hit_stat = paddr == STAT_OFS;
   wire mapped = hit_ctrl || hit_pol || hit_dbr || hit_dbf || hit_shdn || hit_stat;
   wire wr_ctrl = wr_fire && hit_ctrl;
   wire wr_shdn = wr_fire && hit_shdn;

   // Status view of the block
   stat_t stat;
   assign stat.shdn = shdn_q;
   assign stat.data = data_q;
   assign stat.phase = phase_q;
   assign stat.dir = dir_q;
   assign stat.outs = out_q;

   // Read data selection
   wire [31:0] rd_ctrl = {27'h0, cfg_q.cs, cfg_q.mode, cfg_q.en};
   wire [31:0] rd_pol = {28'h0, cfg_q.pol};
   wire [31:0] rd_dbr = {26'h0, cfg_q.dbr};
   wire [31:0] rd_dbf = {26'h0, cfg_q.dbf};
   wire [31:0] rd_shdn = {24'h0, cfg_q.ovr, 2'h0, cfg_q.auto_restart, shdn_q};
   wire [31:0] rd_stat = {24'h0, stat};
   wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                         hit_pol ? rd_pol :
                         hit_dbr ? rd_dbr :
                         hit_dbf ? rd_dbf :
                         hit_shdn ? rd_shdn :
                         hit_stat ? rd_stat : 32'h0;

   // Configuration writes; mode may be rewritten at any time
   always_comb begin
      cfg_d = cfg_q;
      if (wr_ctrl) begin
         cfg_d.en = pwdata[CTRL_EN_BIT];
         cfg_d.mode = pwdata[CTRL_MODE_LSB +: 3];
         cfg_d.cs = pwdata[CTRL_CS_BIT];
      end
      if (wr_fire && hit_pol) begin
         cfg_d.pol = pwdata[3:0];
      end
      if (wr_fire && hit_dbr) begin
         cfg_d.dbr = pwdata[DB_W-1:0];
      end
      if (wr_fire && hit_dbf) begin
         cfg_d.dbf = pwdata[DB_W-1:0];
      end
      if (wr_shdn) begin
         cfg_d.auto_restart = pwdata[SHDN_AUTO_BIT];
         cfg_d.ovr = pwdata[SHDN_OVR_LSB +: 4];
      end
   end

   // Bus answer registers
   always_ff @(posedge clk) begin
      if (reset) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= access && !pready_q;
         pslverr_q <= access && !pready_q && !mapped;
         prdata_q <= (access && !pready_q && !pwrite) ? rd_data : 32'h0;
      end
   end

   // ****************************************
   // Mode decode and dead-band clock
   // ****************************************
   wire en = cfg_q.en;
   wire is_hb = cfg_q.mode == MODE_HALF_BRIDGE;
   wire is_pp = cfg_q.mode == MODE_PUSH_PULL;
   wire is_fb = cfg_q.mode[2:1] == MODE_FB_FWD[2:1];
   wire db_tick = cfg_q.cs ? fast_internal_oscillator : 1'b1;
   wire rise = data_in && !data_q;
   wire fall = !data_in && data_q;

   // ****************************************
   // Shutdown latch
   // ****************************************

   // Fault or firmware sets; firmware or auto restart clears; set wins
   wire shdn_set = shutdown_in || (wr_shdn && pwdata[SHDN_STATE_BIT]);
   wire shdn_clr = (wr_shdn && !pwdata[SHDN_STATE_BIT]) ||
                   (cfg_q.auto_restart && !shutdown_in);
   assign shdn_d = shdn_set || (shdn_q && !shdn_clr);

   // ****************************************
   // Half-bridge dead-band timers
   // ****************************************

   // Count periods since the last edge, cleared by the opposite level
   assign rcnt_d = data_in ? db_step(rcnt_q, db_tick) : DB_ZERO;
   assign fcnt_d = data_in ? DB_ZERO : db_step(fcnt_q, db_tick);
   wire hb_a = data_in && (rcnt_q >= cfg_q.dbr);
   wire hb_b = !data_in && (fcnt_q >= cfg_q.dbf);

   // ****************************************
   // Push-pull sequencer
   // ****************************************
   assign phase_d = (!en || shdn_q) ? 1'b0 :
                    (is_pp && fall) ? !phase_q : phase_q;
   wire pp_a = data_in && !phase_q;
   wire pp_b = data_in && phase_q;

   // ****************************************
   // Full-bridge direction and dead band
   // ****************************************

   // Pending reversal is applied at the next data rise
   wire dir_req = cfg_q.mode[0];
   wire fb_switch = en && is_fb && !shdn_q && rise && (dir_req != dir_q);
   wire [DB_W-1:0] sw_target = dir_req ? cfg_q.dbr : cfg_q.dbf;
   wire [DB_W-1:0] run_target = dir_q ? cfg_q.dbr : cfg_q.dbf;
   assign dir_d = (!en || fb_switch) ? dir_req : dir_q;

   // Dead-band sequence after a direction switch
   always_comb begin
      fbst_d = fbst_q;
      dcnt_d = dcnt_q;
      case (fbst_q)
         DB_IDLE: begin
            if (fb_switch && sw_target != DB_ZERO) begin
               fbst_d = DB_WAIT;
               dcnt_d = DB_ZERO;
            end
         end
         DB_WAIT: begin
            dcnt_d = db_step(dcnt_q, db_tick);
            if (!en || !is_fb || dcnt_q >= run_target) begin
               fbst_d = DB_IDLE;
            end
         end
         default: begin
            fbst_d = DB_IDLE;
         end
      endcase
   end

   // New modulated output stays inactive until the dead band ends
   wire fb_mod = data_in && fbst_q == DB_IDLE;
   wire fb_a = !dir_q;
   // At the switching rise the old modulated output stays off
   wire fb_b = dir_q && fb_mod && !fb_switch;
   wire fb_c = dir_q;
   wire fb_d = !dir_q && fb_mod && !fb_switch;

   // ****************************************
   // Output selection
   // ****************************************

   // Raw drive per mode, order {d, c, b, a}; steering bits unused elsewhere
   wire [3:0] raw = is_hb ? {hb_b, hb_a, hb_b, hb_a} :
                    is_pp ? {pp_b, pp_a, pp_b, pp_a} :
                    is_fb ? {fb_d, fb_c, fb_b, fb_a} :
                    {4{data_in}};
   wire [3:0] drive = raw ^ cfg_q.pol;
   assign out_d = !en ? cfg_q.pol :
                  shdn_q ? cfg_q.ovr : drive;

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= CFG_RESET;
         shdn_q <= 1'b0;
         data_q <= 1'b0;
         phase_q <= 1'b0;
         dir_q <= 1'b0;
         fbst_q <= DB_IDLE;
      end else begin
         cfg_q <= cfg_d;
         shdn_q <= shdn_d;
         data_q <= data_in;
         phase_q <= phase_d;
         dir_q <= dir_d;
         fbst_q <= fbst_d;
      end
   end

   // Counters and output flops
   always_ff @(posedge clk) begin
      if (reset) begin
         rcnt_q <= DB_ZERO;
         fcnt_q <= DB_ZERO;
         dcnt_q <= DB_ZERO;
         out_q <= OUT_RESET;
      end else begin
         rcnt_q <= rcnt_d;
         fcnt_q <= fcnt_d;
         dcnt_q <= dcnt_d;
         out_q <= out_d;
      end
   end

   // Ports
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign bridge_out_a = out_q[0];
   assign bridge_out_b = out_q[1];
   assign bridge_out_c = out_q[2];
   assign bridge_out_d = out_q[3];

   // ****************************************
   // Checks
   // ****************************************

   shutdown_override_a: assert property (
      en && shdn_q |=> out_q == $past(cfg_q.ovr))
      else $error("shutdown output not at override level");

   pp_seq_reset_a: assert property (
      !en || shdn_q |=> !phase_q)
      else $error("push-pull sequencer not reset");

   pp_first_a_a: assert property (
      en && !shdn_q && is_pp && !phase_q |=>
         out_q[0] == ($past(data_in) ^ $past(cfg_q.pol[0])) &&
         out_q[1] == $past(cfg_q.pol[1]))
      else $error("first push-pull pulse not on output a");

   hb_no_overlap_a: assert property (
      en && !shdn_q && is_hb |=>
         !((out_q[0] ^ $past(cfg_q.pol[0])) && (out_q[1] ^ $past(cfg_q.pol[1]))))
      else $error("half-bridge outputs overlap");

   hb_rise_delay_a: assert property (
      en && !shdn_q && is_hb && rise && cfg_q.dbr != DB_ZERO |=>
         out_q[0] == $past(cfg_q.pol[0]))
      else $error("half-bridge turn-on before dead band");

   hb_copy_cd_a: assert property (
      en && !shdn_q && (is_hb || is_pp) |=>
         out_q[2] == (out_q[0] ^ $past(cfg_q.pol[2]) ^ $past(cfg_q.pol[0])))
      else $error("output c does not copy output a");

   fb_dir_hold_a: assert property (
      en && is_fb && !rise |=> dir_q == $past(dir_q))
      else $error("direction changed without data rise");

   fb_deadband_a: assert property (
      fb_switch && sw_target != DB_ZERO |=> fbst_q == DB_WAIT && !fb_b && !fb_d)
      else $error("no dead band after direction switch");

   fb_static_a: assert property (
      en && !shdn_q && is_fb |=> out_q[0] == ($past(!dir_q) ^ $past(cfg_q.pol[0])))
      else $error("static output a wrong in full bridge");

   fb_static_c_a: assert property (
      en && !shdn_q && is_fb |=> out_q[2] == ($past(dir_q) ^ $past(cfg_q.pol[2])))
      else $error("static output c wrong in full bridge");

   fb_mod_off_a: assert property (
      fb_switch |=>
         out_q[3] == $past(cfg_q.pol[3]) && out_q[1] == $past(cfg_q.pol[1]))
      else $error("modulated output active at direction switch");

   apb_ready_a: assert property (
      access && !pready_q |=> pready_q ##1 !pready_q)
      else $error("ready not a single pulse");

endmodule

/* verification/bridge_load.sv */
`timescale 1ns/1ps
// ********************
// Power stage model
// ********************
module bridge_load (
   input wire logic clk,
   input wire logic [3:0] outs,
   input wire logic [3:0] pol,
   output int shoot_count
);
   logic [3:0] sw_on;
   // Switch conducts when its drive is at the active level
   assign sw_on = outs ^ pol;
   // Count cycles where both switches of one leg conduct
   initial shoot_count = 0;
   always @(posedge clk) begin
      if ((sw_on[0] && sw_on[1]) || (sw_on[2] && sw_on[3])) begin
         shoot_count <= shoot_count + 1;
      end
   end
endmodule

/* verification/complementary_waveform_gen_tb.sv */
`timescale 1ns/1ps
module complementary_waveform_gen_tb;
   import cwg_pkg::*;
   // ********************
   // Signals
   // ********************
   logic clk, reset, psel, penable, pwrite, data_in, osc, shutdown_in, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, rd;
   logic [3:0] pol_cfg;
   logic [1:0] tick_q;
   logic [3:0] seen;
   wire [31:0] prdata;
   wire pready, pslverr, oa, ob, oc, od;
   wire [3:0] outs = {od, oc, ob, oa};
   int err_count, num_checks, shoot_count, n, shoot_base;

   complementary_waveform_gen i_dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(data_in),
      .fast_internal_oscillator(osc), .shutdown_in(shutdown_in),
      .bridge_out_a(oa), .bridge_out_b(ob), .bridge_out_c(oc), .bridge_out_d(od));
   bridge_load i_load (.clk(clk), .outs(outs), .pol(pol_cfg), .shoot_count(shoot_count));

   // Clock and dead-band tick, one tick every four cycles
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      tick_q <= tick_q + 2'h1;
      osc <= (tick_q == 2'h3);
   end

   // ********************
   // Helpers
   // ********************
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         $display("ERROR pready expected 1 seen %b", pready);
         err_count++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Edges until an output is seen high
   task automatic wait_hi(input int i, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (outs[i] !== 1'b1 && cnt < 300);
   endtask

   // One data pulse, collecting which outputs went high
   task automatic pulse();
      data_in <= 1'b1;
      seen = 4'h0;
      repeat (4) @(posedge clk) seen |= outs;
      data_in <= 1'b0;
      repeat (4) @(posedge clk) seen |= outs;
   endtask

   // ********************
   // Scenarios
   // ********************
   task automatic t_reset();
      chk("outs", 32'h0, {28'h0, outs});
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      // Steering: all four outputs follow data; both legs conduct on purpose
      apb(1'b1, CTRL_OFS, 32'h1);
      data_in <= 1'b1;
      repeat (2) @(posedge clk);
      chk("steer follow", 32'hf, {28'h0, outs});
      data_in <= 1'b0;
      apb(1'b1, CTRL_OFS, 32'h0);
      chk("steer idle", 32'h0, {28'h0, outs});
      shoot_base = shoot_count;
      $display("t_reset done");
   endtask

   task automatic t_half();
      apb(1'b1, DBR_OFS, 32'h2);
      apb(1'b1, DBF_OFS, 32'h3);
      apb(1'b1, CTRL_OFS, 32'h9);
      repeat (8) @(posedge clk);
      data_in <= 1'b1;
      wait_hi(0, n);
      chk("rise delay", 32'h4, 32'(n));
      chk("a b c d", 32'h5, {28'h0, outs});
      data_in <= 1'b0;
      wait_hi(1, n);
      chk("fall delay", 32'h5, 32'(n));
      chk("a b c d", 32'ha, {28'h0, outs});
      apb(1'b1, CTRL_OFS, 32'h0);
      pol_cfg <= 4'h5;
      apb(1'b1, POL_OFS, 32'h5);
      repeat (3) @(posedge clk);
      chk("pol idle", 32'h5, {28'h0, outs});
      pol_cfg <= 4'h0;
      apb(1'b1, POL_OFS, 32'h0);
      $display("t_half done");
   endtask

   task automatic t_pp();
      apb(1'b1, DBR_OFS, 32'h0);
      apb(1'b1, DBF_OFS, 32'h0);
      apb(1'b1, SHDN_OFS, 32'h90);
      apb(1'b1, CTRL_OFS, 32'hb);
      for (int i = 0; i < 3; i++) begin
         pulse();
         chk("pp pulse", (i % 2) ? 32'ha : 32'h5, {28'h0, seen});
      end
      shutdown_in <= 1'b1;
      repeat (4) @(posedge clk);
      chk("override", 32'h9, {28'h0, outs});
      shutdown_in <= 1'b0;
      apb(1'b1, SHDN_OFS, 32'h90);
      apb(1'b1, SHDN_OFS, 32'h0);
      pulse();
      chk("after shdn", 32'h5, {28'h0, seen});
      pulse();
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b1, CTRL_OFS, 32'hb);
      pulse();
      chk("after dis", 32'h5, {28'h0, seen});
      apb(1'b1, CTRL_OFS, 32'h0);
      $display("t_pp done");
   endtask

   task automatic t_fb();
      apb(1'b1, DBR_OFS, 32'h3);
      apb(1'b1, DBF_OFS, 32'h3);
      apb(1'b1, CTRL_OFS, 32'h15);
      repeat (4) @(posedge clk);
      chk("fwd idle", 32'h1, {28'h0, outs});
      data_in <= 1'b1;
      repeat (3) @(posedge clk);
      chk("fwd mod", 32'h9, {28'h0, outs});
      data_in <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b1, CTRL_OFS, 32'h17);
      repeat (4) @(posedge clk);
      chk("dir held", 32'h1, {28'h0, outs});
      data_in <= 1'b1;
      repeat (3) @(posedge clk);
      chk("swap", 32'h4, {28'h0, outs});
      wait_hi(1, n);
      chk("dir dead band", 32'h1, {31'h0, (n >= 10 && n <= 20)});
      chk("rev mod", 32'h6, {28'h0, outs});
      data_in <= 1'b0;
      $display("t_fb done");
   endtask

   // ********************
   // Main sequence and watchdog
   // ********************
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      data_in = 1'b0;
      osc = 1'b0;
      tick_q = 2'h0;
      shutdown_in = 1'b0;
      pol_cfg = 4'h0;
      err_count = 0;
      num_checks = 0;
      shoot_base = 0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_half();
      t_pp();
      t_fb();
      chk("shoot through", 32'h0, 32'(shoot_count - shoot_base));
      wrap_up();
   end

   initial begin
      #20000;
      err_count++;
      wrap_up();
   end
endmodule
